/* File: rtl/rrl_pkg.sv */
package rrl_pkg;
  // instruction word layout
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int FADDR_W = 7;
  // fixed opcodes and match masks
  localparam logic [13:0] OP_IRQ_RET = 14'h0009;
  localparam logic [13:0] OP_SUB_RET = 14'h0008;
  localparam logic [13:0] LIT_RET_MASK = 14'h3c00;
  localparam logic [13:0] LIT_RET_CODE = 14'h3400;
  localparam logic [13:0] ROT_MASK = 14'h3f00;
  localparam logic [13:0] ROT_CODE = 14'h0d00;
  // field positions
  localparam int DEST_BIT = 7;
  localparam int IRQ_EN_BIT = 7;
  localparam int MSB_BIT = 7;
  // cycle counts
  localparam logic [1:0] RET_CYCLES = 2'h2;
  localparam logic [1:0] ROT_CYCLES = 2'h1;
  // reset values
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;

  // issue request from the fetch stage
  typedef struct packed {
    logic valid;
    logic [13:0] insn;
  } rrl_issue_t;

  // write to the file register space
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } rrl_fwrite_t;
endpackage

/* File: rtl/rrl_core.sv */
`timescale 1ns/1ps
// Behaviour
// - interrupt return pops stack into PC
// - interrupt return sets global irq enable
// - interrupt return takes two cycles
// - literal return loads W with literal
// - literal return pops stack into PC
// - literal return takes two cycles
// - rotate left through carry, carry only
// - destination bit 0 writes W
// - destination bit 1 writes file register
module rrl_core (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // instruction issue
  input wire rrl_pkg::rrl_issue_t issue,
  output logic issue_ready,
  // stack
  input wire logic [12:0] top_of_stack,
  output logic stack_pop,
  // file register read port (combinational, same clock)
  output logic [6:0] file_raddr,
  input wire logic [7:0] file_rdata,
  // file register write
  output rrl_pkg::rrl_fwrite_t file_wr,
  // architectural state
  output logic [12:0] pc,
  output logic pc_load,
  output logic [7:0] w_reg,
  output logic carry,
  output logic [7:0] interrupt_control_reg,
  output logic global_irq_enable,
  output logic busy,
  output logic done
);
  typedef enum logic [1:0] {RRL_IDLE, RRL_RET2} rrl_state_t;

  rrl_state_t state_r;
  logic [1:0] cyc_r;
  logic ret_last;
  // decoded opcode classes of the word on offer
  logic is_irq_ret;
  logic is_sub_ret;
  logic is_lit_ret;
  logic is_rot;
  logic is_ret;
  logic rot_to_w;
  logic rot_to_file;
  logic take;
  logic [7:0] rot_val;
  logic rot_carry;
  // registered state behind the outputs
  logic [12:0] pc_r;
  logic pc_load_r;
  logic [7:0] w_r;
  logic carry_r;
  logic [7:0] intctl_r;
  logic pop_r;
  logic done_r;
  logic fwe_r;
  logic [6:0] faddr_r;
  logic [7:0] fdata_r;

  // decode; literal return ignores its two don't-care bits, and any other
  // word is still taken but changes nothing here, as another unit owns it
  assign is_irq_ret = issue.insn == rrl_pkg::OP_IRQ_RET;
  assign is_sub_ret = issue.insn == rrl_pkg::OP_SUB_RET;
  assign is_lit_ret = (issue.insn & rrl_pkg::LIT_RET_MASK) ==
                      rrl_pkg::LIT_RET_CODE;
  assign is_rot = (issue.insn & rrl_pkg::ROT_MASK) == rrl_pkg::ROT_CODE;
  assign is_ret = is_irq_ret | is_sub_ret | is_lit_ret;
  // the destination bit splits rotate into its two write targets
  assign rot_to_w = is_rot & ~issue.insn[rrl_pkg::DEST_BIT];
  assign rot_to_file = is_rot & issue.insn[rrl_pkg::DEST_BIT];

  // a return holds the issue port for its second cycle; the fetch stage
  // must keep the next word offered until ready comes back
  assign issue_ready = state_r == RRL_IDLE;
  assign take = issue.valid & issue_ready;

  // rotate datapath: old carry in at bit 0, old bit 7 out; the file read
  // is combinational, a registered file would cost the one-cycle figure
  assign file_raddr = issue.insn[6:0];
  assign rot_val = {file_rdata[6:0], carry_r};
  assign rot_carry = file_rdata[rrl_pkg::MSB_BIT];

  // cycles already spent on the return in flight; the count, not the
  // state alone, ends a return, so a longer return is one constant away
  always_ff @(posedge clk) begin
    if (srst) begin
      cyc_r <= 2'h0;
    end else if (take && is_ret) begin
      cyc_r <= 2'h1;
    end else if (state_r == RRL_RET2) begin
      cyc_r <= cyc_r + 2'h1;
    end
  end

  // last cycle of a return: the instruction retires here
  assign ret_last = (state_r == RRL_RET2) &&
                    (cyc_r == rrl_pkg::RET_CYCLES - 2'h1);

  // return sequencer: first cycle pops, the last one completes;
  // nothing new is taken while a return is still in flight
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= RRL_IDLE;
    end else begin
      case (state_r)
        RRL_IDLE: begin
          if (take && is_ret) begin
            state_r <= RRL_RET2;
          end
        end
        RRL_RET2: begin
          if (ret_last) begin
            state_r <= RRL_IDLE;
          end
        end
        default: state_r <= RRL_IDLE;
      endcase
    end
  end

  // one pop per return, in its first cycle, so the stack moves once
  always_ff @(posedge clk) begin
    if (srst) begin
      pop_r <= 1'b0;
    end else begin
      pop_r <= take & is_ret;
    end
  end

  // load strobe travels with the new pc so fetch redirects at once
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_load_r <= 1'b0;
    end else begin
      pc_load_r <= take & is_ret;
    end
  end

  // pc takes the top of stack at the taking edge, before the pop lands
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_r <= rrl_pkg::PC_RST;
    end else if (take && is_ret) begin
      pc_r <= top_of_stack;
    end
  end

  // working register: literal return or rotate with d = 0;
  // no other instruction of this block writes it
  always_ff @(posedge clk) begin
    if (srst) begin
      w_r <= rrl_pkg::W_RST;
    end else if (take && is_lit_ret) begin
      w_r <= issue.insn[7:0];
    end else if (take && rot_to_w) begin
      w_r <= rot_val;
    end
  end

  // carry is the only status touched, and only by rotate;
  // every return leaves it as it stands
  always_ff @(posedge clk) begin
    if (srst) begin
      carry_r <= 1'b0;
    end else if (take && is_rot) begin
      carry_r <= rot_carry;
    end
  end

  // write strobe for rotate with d = 1; one pulse, single cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      fwe_r <= 1'b0;
    end else begin
      fwe_r <= take & rot_to_file;
    end
  end

  // address and data move only on a write, which keeps the file
  // bus quiet between writes
  always_ff @(posedge clk) begin
    if (srst) begin
      faddr_r <= '0;
      fdata_r <= '0;
    end else if (take && rot_to_file) begin
      faddr_r <= issue.insn[6:0];
      fdata_r <= rot_val;
    end
  end

  // interrupt control: only interrupt return sets the enable bit;
  // the other bits belong to the interrupt unit and stay untouched
  always_ff @(posedge clk) begin
    if (srst) begin
      intctl_r <= rrl_pkg::INTCTL_RST;
    end else if (take && is_irq_ret) begin
      intctl_r[rrl_pkg::IRQ_EN_BIT] <= 1'b1;
    end
  end

  // completion strobe: rotate ends now, returns one cycle later;
  // a return shows it one edge after its pop
  always_ff @(posedge clk) begin
    if (srst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (take & is_rot) | ret_last;
    end
  end

  // outputs straight from their registers
  assign pc = pc_r;
  assign pc_load = pc_load_r;
  assign stack_pop = pop_r;
  assign w_reg = w_r;
  assign carry = carry_r;
  assign file_wr = '{we: fwe_r, addr: faddr_r, data: fdata_r};
  assign interrupt_control_reg = intctl_r;
  assign global_irq_enable = intctl_r[rrl_pkg::IRQ_EN_BIT];
  assign busy = state_r != RRL_IDLE;
  assign done = done_r;
endmodule

/* File: verification/rrl_core_assertions.sv */
`timescale 1ns/1ps
module rrl_chk (
  // inputs, plus the issue_ready output
  input wire logic clk,
  input wire logic srst,
  input wire rrl_pkg::rrl_issue_t issue,
  input wire logic issue_ready,
  input wire logic [12:0] top_of_stack,
  input wire logic [7:0] file_rdata,
  // outputs
  input wire logic stack_pop,
  input wire rrl_pkg::rrl_fwrite_t file_wr,
  input wire logic [12:0] pc,
  input wire logic [7:0] w_reg,
  input wire logic carry,
  input wire logic global_irq_enable,
  input wire logic done
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // taken opcodes; literal and rotate match under their masks
  wire logic tk = issue.valid & issue_ready;
  wire logic [13:0] i = issue.insn;
  wire logic ir = tk & i == rrl_pkg::OP_IRQ_RET;
  wire logic sr = tk & i == rrl_pkg::OP_SUB_RET;
  wire logic lr = tk & (i & rrl_pkg::LIT_RET_MASK) == rrl_pkg::LIT_RET_CODE;
  wire logic rt = tk & (i & rrl_pkg::ROT_MASK) == rrl_pkg::ROT_CODE;
  // old carry enters at the bottom, so one value serves both destinations
  wire logic [7:0] rl = {file_rdata[6:0], carry};
  a_irq_pop: assert property (ir |=>
    stack_pop && pc == $past(top_of_stack)) else $error("irq pop");
  a_irq_enable: assert property (ir |=> global_irq_enable)
    else $error("irq enable not set");
  a_ret_cyc: assert property (ir | sr | lr |=> !done ##1 done)
    else $error("return length");
  a_sub_keep: assert property (sr |=> $stable(carry) &&
    $stable(global_irq_enable) && pc == $past(top_of_stack)) else $error("sub");
  a_lit_load: assert property (lr |=> w_reg == $past(i[7:0]) &&
    pc == $past(top_of_stack)) else $error("lit");
  a_rot_carry: assert property (rt |=>
    done && carry == $past(file_rdata[7])) else $error("rot carry");
  a_rot_w: assert property (rt & !i[7] |=>
    !file_wr.we && w_reg == $past(rl)) else $error("rot to w");
  a_rot_f: assert property (rt & i[7] |=>
    file_wr.we && file_wr.data == $past(rl)) else $error("rot to f");
  a_irq_flags: assert property (ir |=> $stable(carry))
    else $error("irq return moved carry");
  a_lit_flags: assert property (lr |=> $stable(carry) &&
    $stable(global_irq_enable)) else $error("lit return moved flags");
  a_ret_refuse: assert property (ir | sr | lr |=>
    !issue_ready ##1 issue_ready) else $error("return refusal");
  a_rot_addr: assert property (rt & i[7] |=>
    file_wr.addr == $past(i[6:0])) else $error("rot address");
endmodule
bind rrl_core rrl_chk i_chk (.*);

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
  // stimulus and observed outputs
  logic clk = 1'b0;
  logic srst = 1'b1;
  rrl_pkg::rrl_issue_t issue = '0;
  logic [12:0] stack_top = 13'h0000;
  logic [7:0] rd = 8'h00;
  logic [12:0] pc;
  logic [7:0] w, icr;
  logic [6:0] raddr;
  logic c, g, rdy, pop, dn, pc_ld, bsy;
  rrl_pkg::rrl_fwrite_t fw;
  int failures = 0;
  int compares = 0;
  rrl_core i_dut (.clk(clk), .srst(srst), .issue(issue), .issue_ready(rdy),
    .top_of_stack(stack_top), .stack_pop(pop), .file_raddr(raddr),
    .file_rdata(rd), .file_wr(fw), .pc(pc), .pc_load(pc_ld), .w_reg(w),
    .carry(c), .busy(bsy), .interrupt_control_reg(icr),
    .global_irq_enable(g), .done(dn));
  // free-running clock
  initial forever #5 clk = ~clk;
  task results;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic ok);
    compares++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: bad output", $time);
    end
  endtask
  // offer one word 1 ns after an edge; returns 1 ns after the taking edge
  task go(input logic [13:0] op);
    issue = '{1'b1, op};
    @(posedge clk);
    #1;
  endtask
  // sub return runs first so the irq enable must still read 0 there
  task t_ret(input logic [13:0] op, input logic [12:0] a, input logic [7:0] k);
    stack_top = a;
    go(op);
    issue.valid = 1'b0;
    chk(pc === a && pop === 1'b1 && pc_ld === 1'b1);
    chk(rdy === 1'b0 && bsy === 1'b1 && dn === 1'b0);
    chk(op[13] ? w === k : g === (op === rrl_pkg::OP_IRQ_RET));
    chk(icr === (op === rrl_pkg::OP_SUB_RET ? 8'h00 : 8'h80));
    @(posedge clk);
    #1;
    chk(dn === 1'b1 && rdy === 1'b1 && bsy === 1'b0);
  endtask
  // two rotates back to back: first to w, then into register 127
  task t_rot;
    rd = 8'h96;
    go(14'h0d05);
    chk(w === 8'h2c && c === 1'b1 && dn === 1'b1);
    chk(fw.we === 1'b0 && raddr === 7'h05);
    rd = 8'h41;
    go(14'h0dff);
    issue.valid = 1'b0;
    chk(fw === {1'b1, 7'h7f, 8'h83} && c === 1'b0 && w === 8'h2c);
    chk(dn === 1'b1 && raddr === 7'h7f);
  endtask
  // a rotate offered in the refused cycle waits for the next edge
  task t_hold;
    @(posedge clk);
    #1;
    stack_top = 13'h0777;
    go(rrl_pkg::OP_SUB_RET);
    chk(pc === 13'h0777 && pc_ld === 1'b1 && bsy === 1'b1);
    rd = 8'hc0;
    issue = '{1'b1, 14'h0d85};
    @(posedge clk);
    #1;
    chk(fw.we === 1'b0 && c === 1'b0 && dn === 1'b1);
    chk(rdy === 1'b1 && raddr === 7'h05);
    @(posedge clk);
    #1;
    issue.valid = 1'b0;
    chk(fw === {1'b1, 7'h05, 8'h80} && c === 1'b1);
    chk(dn === 1'b1 && w === 8'h2c);
  endtask
  // watchdog, far beyond the some twenty cycles the run needs
  initial begin
    #5000;
    failures++;
    results;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    t_ret(rrl_pkg::OP_SUB_RET, 13'h0123, 8'h00);
    t_ret(rrl_pkg::OP_IRQ_RET, 13'h1abc, 8'h00);
    t_ret(14'h37ff, 13'h0001, 8'hff);
    t_ret(14'h3412, 13'h0002, 8'h12);
    t_rot;
    t_hold;
    results;
  end
endmodule
